// file: verilog/pmwc_regs.vh
/*
 * Register map, field positions and reset values of the power-mode and
 * wake-up controller. Assumes a 32-bit AXI4-Lite register bus.
 */
`ifndef PMWC_REGS_VH
`define PMWC_REGS_VH

// Byte addresses of the register words
`define PMWC_ADDR_PWR_CTRL   8'h00
`define PMWC_ADDR_P1_WAKE    8'h04
`define PMWC_ADDR_SEL_WAKE   8'h08
`define PMWC_ADDR_WAKE_CFG   8'h0C
`define PMWC_ADDR_IRQ_CFG    8'h10
`define PMWC_ADDR_STATUS     8'h14

// power_control_reg fields
`define PMWC_HALT_BIT        0
`define PMWC_SLEEP_BIT       1

// wake_cfg fields
`define PMWC_SEL_LSB         0
`define PMWC_SEL_MSB         1
`define PMWC_CMP_IDLE_BIT    2
`define PMWC_WDT_IDLE_BIT    3
`define PMWC_WDT_PD_BIT      4

// irq_cfg fields: enables in byte 0, level-mode in byte 1
`define PMWC_IRQ_EN_LSB      0
`define PMWC_IRQ_EN_MSB      5
`define PMWC_IRQ_LVL_LSB     8
`define PMWC_IRQ_LVL_MSB     13

// Wake-port selector codes
`define PMWC_SEL_PORT0       2'h0
`define PMWC_SEL_PORT2       2'h1
`define PMWC_SEL_PORT3       2'h2
`define PMWC_SEL_PORT5       2'h3

// Wake cause codes shown in status
`define PMWC_CAUSE_NONE      3'h0
`define PMWC_CAUSE_IRQ       3'h1
`define PMWC_CAUSE_GPIO      3'h2
`define PMWC_CAUSE_RESET     3'h3
`define PMWC_CAUSE_WDT       3'h4

// Reset values and bus answers
`define PMWC_RST_BYTE        8'h00
`define PMWC_RST_WORD        32'h0000_0000
`define PMWC_RESP_OKAY       2'h0
`define PMWC_RESP_SLVERR     2'h2

`endif

// file: verilog/pmwc_power_ctrl.v
/*
 * Power-mode and wake-up controller: Idle and Power-down entry, wake-up
 * by interrupt, reset pin, GPIO falling edge and watchdog, and the timed
 * oscillator restart. Assumes one 20 MHz clock, a synchronous active-low
 * power-on reset, and wake pins that arrive asynchronously.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
// What this block does
// - Halt request gates CPU clock; CPU state simply kept.
// - Port pins hold their levels throughout Idle.
// - Timers, PWM timer and UART keep running in Idle.
// - Comparator and watchdog run in Idle only if their options set.
// - Any enabled interrupt or reset ends Idle; interrupt served at once.
// - After interrupt return, execution continues after the Idle entry.
// - Deep-sleep request stops oscillator and powers down flash.
// - RAM kept in Power-down; registers not guaranteed at low supply.
// - Power-down ends only on reset, interrupt, GPIO or non-stop watchdog.
// - External line wakes Power-down only if enabled and level mode.
// - Interrupt wake restarts oscillator, holds CPU until counter full.
// - Reset pin rise in Power-down restarts oscillator with timed hold.
// - Reset ending Idle: two machine cycles run with RAM blocked.
// - Every port 1 pin and selected port pin has a wake enable.
// - Lines 0,1,4,5 pins keep GPIO wake; lines 2,3 need enabled irq.
// - GPIO fall ends Power-down with timed restart, no interrupt.
// - GPIO fall ends Idle with no interrupt, resuming in place.
// - Deep-sleep bit 1, halt bit 0; cleared by software, or by exit from the bit's own mode only.
// - Wake pins trigger on falling edge in Power-down and Idle.
// - Selector codes 00,01,10,11 pick ports 0, 2, 3, 5.
`include "pmwc_regs.vh"

module pmwc_power_ctrl #(
    parameter RESTART_CYCLES = 1024, // Oscillator restart timeout
    parameter MACHINE_CYCLE  = 1,    // Clocks per machine cycle
    parameter GRACE_MC       = 2     // Machine cycles run before reset
) (
    input  wire        clk_i,
    input  wire        rst_n_i,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Pins and partners
    input  wire        rst_pin_i,
    input  wire [5:0]  ext_irq_line_n_i,
    input  wire [7:0]  port1_pins_i,
    input  wire [7:0]  port0_pins_i,
    input  wire [7:0]  port2_pins_i,
    input  wire [7:0]  port3_pins_i,
    input  wire [7:0]  port5_pins_i,
    input  wire        irq_pending_i,
    input  wire        wdt_wake_i,
    output reg         cpu_clk_en_o,
    output reg         cpu_reset_o,
    output reg         port_hold_o,
    output reg         periph_run_o,
    output reg         cmp_run_o,
    output reg         wdt_run_o,
    output reg         osc_en_o,
    output reg         flash_pd_o,
    output reg         ram_block_o,
    output reg         wake_pulse_o
);
    localparam S_RUN     = 5'h01;
    localparam S_IDLE    = 5'h02;
    localparam S_PDOWN   = 5'h04;
    localparam S_RESTART = 5'h08;
    localparam S_GRACE   = 5'h10;
    localparam integer RESTART_INT = RESTART_CYCLES - 1;
    localparam integer GRACE_INT   = GRACE_MC * MACHINE_CYCLE - 1;
    localparam [15:0]  RESTART_LAST = RESTART_INT[15:0];
    localparam [15:0]  GRACE_LAST   = GRACE_INT[15:0];

    // Byte-lane merge of a write into a stored word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = data[i*8 +: 8];
        end
    endfunction

    // Port picked by the selector
    function [7:0] pick_port;
        input [1:0] sel;
        input [7:0] p0;
        input [7:0] p2;
        input [7:0] p3;
        input [7:0] p5;
        begin
            case (sel)
                `PMWC_SEL_PORT0: pick_port = p0;
                `PMWC_SEL_PORT2: pick_port = p2;
                `PMWC_SEL_PORT3: pick_port = p3;
                default:         pick_port = p5;
            endcase
        end
    endfunction

    reg  [4:0]  state;
    reg  [15:0] count;
    reg  [2:0]  cause;
    reg  [1:0]  pwr_ctrl;
    reg  [7:0]  p1_wake_en;
    reg  [7:0]  sel_wake_en;
    reg  [4:0]  wake_cfg;
    reg  [13:0] irq_cfg;
    reg  [46:0] sync1;
    reg  [46:0] sync2;
    reg  [46:0] prev;
    reg         aw_full;
    reg         w_full;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;

    // Two-flop synchronisers for every pin; prev reads only the second
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sync1 <= 47'h0;
            sync2 <= 47'h0;
            prev  <= 47'h0;
        end
        else
        begin
            sync1 <= {rst_pin_i, port5_pins_i, port3_pins_i, port2_pins_i,
                      port0_pins_i, port1_pins_i, ext_irq_line_n_i};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    wire [5:0]  irq_n    = sync2[5:0];
    wire [7:0]  p1_fall  = prev[13:6] & ~sync2[13:6];
    wire [7:0]  sel_fall = pick_port(wake_cfg[`PMWC_SEL_MSB:`PMWC_SEL_LSB],
                               prev[21:14] & ~sync2[21:14],
                               prev[29:22] & ~sync2[29:22],
                               prev[37:30] & ~sync2[37:30],
                               prev[45:38] & ~sync2[45:38]);
    wire        rst_pin  = sync2[46];
    wire        rst_rise = sync2[46] & ~prev[46];

    // Falling edges on enabled pins; shared lines 0,1,4,5 keep wake
    // whatever their irq enable, lines 2,3 never sit on a selectable port
    wire gpio_wake = |(p1_fall & p1_wake_en) |
                     |(sel_fall & sel_wake_en);
    // Level-mode enabled lines only; a low level covers the falling edge
    wire irq_wake = |(~irq_n & irq_cfg[`PMWC_IRQ_EN_MSB:`PMWC_IRQ_EN_LSB]
                      & irq_cfg[`PMWC_IRQ_LVL_MSB:`PMWC_IRQ_LVL_LSB]);
    wire wdt_pd   = wdt_wake_i & wake_cfg[`PMWC_WDT_PD_BIT];
    wire wdt_idle = wdt_wake_i & wake_cfg[`PMWC_WDT_IDLE_BIT];

    // Bus handshakes are combinational; data and answers are registered
    assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_full & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire have_aw = aw_full | aw_take;
    wire have_w  = w_full | w_take;
    wire wr_do   = have_aw & have_w;
    wire [7:0]  wa = aw_full ? aw_addr : s_axi_awaddr;
    wire [31:0] wd = w_full ? w_data : s_axi_wdata;
    wire [3:0]  ws = w_full ? w_strb : s_axi_wstrb;
    wire wr_pwr  = wr_do & (wa == `PMWC_ADDR_PWR_CTRL);
    wire [31:0] pwr_new = merge({30'h0, pwr_ctrl}, wd, ws);
    wire [31:0] p1_new  = merge({24'h0, p1_wake_en}, wd, ws);
    wire [31:0] sel_new = merge({24'h0, sel_wake_en}, wd, ws);
    wire [31:0] cfg_new = merge({27'h0, wake_cfg}, wd, ws);
    wire [31:0] irq_new = merge({18'h0, irq_cfg}, wd, ws);

    wire in_sleep = state == S_IDLE || state == S_PDOWN;

    // Address and data may arrive in either order; held until paired
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            aw_addr      <= `PMWC_RST_BYTE;
            w_data       <= `PMWC_RST_WORD;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PMWC_RESP_OKAY;
            p1_wake_en   <= `PMWC_RST_BYTE;
            sel_wake_en  <= `PMWC_RST_BYTE;
            wake_cfg     <= 5'h00;
            irq_cfg      <= 14'h0000;
        end
        else
        begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (aw_take)
                aw_addr <= s_axi_awaddr;
            if (w_take)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            aw_full <= have_aw & ~wr_do;
            w_full  <= have_w & ~wr_do;
            if (wr_do)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `PMWC_RESP_OKAY;
                if (wa == `PMWC_ADDR_P1_WAKE)
                    p1_wake_en <= p1_new[7:0];
                else if (wa == `PMWC_ADDR_SEL_WAKE)
                    sel_wake_en <= sel_new[7:0];
                else if (wa == `PMWC_ADDR_WAKE_CFG)
                    wake_cfg <= cfg_new[4:0];
                else if (wa == `PMWC_ADDR_IRQ_CFG)
                    irq_cfg <= irq_new[13:0];
                else if (wa != `PMWC_ADDR_PWR_CTRL
                         && wa != `PMWC_ADDR_STATUS)
                    s_axi_bresp <= `PMWC_RESP_SLVERR;
            end
        end
    end

    // Read side: one answer per address, unmapped answers SLVERR
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `PMWC_RST_WORD;
            s_axi_rresp  <= `PMWC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PMWC_RESP_OKAY;
            if (s_axi_araddr == `PMWC_ADDR_PWR_CTRL)
                s_axi_rdata <= {30'h0, pwr_ctrl};
            else if (s_axi_araddr == `PMWC_ADDR_P1_WAKE)
                s_axi_rdata <= {24'h0, p1_wake_en};
            else if (s_axi_araddr == `PMWC_ADDR_SEL_WAKE)
                s_axi_rdata <= {24'h0, sel_wake_en};
            else if (s_axi_araddr == `PMWC_ADDR_WAKE_CFG)
                s_axi_rdata <= {27'h0, wake_cfg};
            else if (s_axi_araddr == `PMWC_ADDR_IRQ_CFG)
                s_axi_rdata <= {18'h0, irq_cfg};
            else if (s_axi_araddr == `PMWC_ADDR_STATUS)
                s_axi_rdata <= {24'h0, 1'b0, cause, state[4:1]};
            else
            begin
                s_axi_rdata <= `PMWC_RST_WORD;
                s_axi_rresp <= `PMWC_RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Mode sequencer. A write to power_control_reg is ignored while
    // asleep, since the CPU cannot issue one then.
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state        <= S_RUN;
            count        <= 16'h0;
            cause        <= `PMWC_CAUSE_NONE;
            pwr_ctrl     <= 2'h0;
            wake_pulse_o <= 1'b0;
        end
        else
        begin
            wake_pulse_o <= 1'b0;
            case (state)
                S_RUN:
                begin
                    if (wr_pwr)
                    begin
                        pwr_ctrl <= pwr_new[1:0];
                        // Deep sleep wins when both bits are written
                        if (pwr_new[`PMWC_SLEEP_BIT])
                            state <= S_PDOWN;
                        else if (pwr_new[`PMWC_HALT_BIT])
                            state <= S_IDLE;
                    end
                end
                S_IDLE:
                begin
                    if (rst_rise)
                    begin
                        state <= S_GRACE;
                        count <= 16'h0;
                        cause <= `PMWC_CAUSE_RESET;
                        pwr_ctrl[`PMWC_HALT_BIT] <= 1'b0;
                    end
                    else if (irq_pending_i || gpio_wake || wdt_idle)
                    begin
                        // Clock back next edge; no PC change on resume
                        state <= S_RUN;
                        wake_pulse_o <= 1'b1;
                        cause <= irq_pending_i ? `PMWC_CAUSE_IRQ :
                                 gpio_wake ? `PMWC_CAUSE_GPIO :
                                 `PMWC_CAUSE_WDT;
                        pwr_ctrl[`PMWC_HALT_BIT] <= 1'b0;
                    end
                end
                S_PDOWN:
                begin
                    // Only these sources may end deep sleep
                    if (rst_rise || irq_wake || gpio_wake || wdt_pd)
                    begin
                        state <= S_RESTART;
                        count <= 16'h0;
                        cause <= rst_rise ? `PMWC_CAUSE_RESET :
                                 irq_wake ? `PMWC_CAUSE_IRQ :
                                 gpio_wake ? `PMWC_CAUSE_GPIO :
                                 `PMWC_CAUSE_WDT;
                        pwr_ctrl[`PMWC_SLEEP_BIT] <= 1'b0;
                    end
                end
                S_RESTART:
                begin
                    // Same timeout for every deep-sleep exit
                    if (count == RESTART_LAST)
                    begin
                        state <= S_RUN;
                        wake_pulse_o <= 1'b1;
                    end
                    else
                        count <= count + 16'h1;
                end
                S_GRACE:
                begin
                    if (count == GRACE_LAST)
                        state <= S_RUN;
                    else
                        count <= count + 16'h1;
                end
                default:
                    state <= S_RUN;
            endcase
        end
    end

    // Clock, power and hold controls, all registered from state
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cpu_clk_en_o <= 1'b1;
            cpu_reset_o  <= 1'b0;
            port_hold_o  <= 1'b0;
            periph_run_o <= 1'b1;
            cmp_run_o    <= 1'b1;
            wdt_run_o    <= 1'b1;
            osc_en_o     <= 1'b1;
            flash_pd_o   <= 1'b0;
            ram_block_o  <= 1'b0;
        end
        else
        begin
            // CPU clock gated; registers and RAM untouched while stopped
            cpu_clk_en_o <= ~in_sleep & state != S_RESTART;
            // Core held in reset while the pin is high, except in Idle and grace; the pin is kept
            // high past the restart timeout by the reset source
            cpu_reset_o  <= rst_pin & state != S_GRACE &
                            state != S_IDLE;
            port_hold_o  <= state == S_IDLE;
            periph_run_o <= state != S_PDOWN;
            cmp_run_o    <= state != S_PDOWN &&
                            (state != S_IDLE ||
                             wake_cfg[`PMWC_CMP_IDLE_BIT]);
            wdt_run_o    <= state == S_PDOWN ? wake_cfg[`PMWC_WDT_PD_BIT] :
                            state != S_IDLE ||
                            wake_cfg[`PMWC_WDT_IDLE_BIT];
            // Oscillator off, flash down; RAM retention is analog
            osc_en_o     <= state != S_PDOWN;
            flash_pd_o   <= state == S_PDOWN;
            ram_block_o  <= state == S_GRACE;
        end
    end
endmodule // pmwc_power_ctrl

// file: tb/pmwc_power_ctrl_sva.sv
/*
 * Checker for the power-mode controller: mode outputs, wake timing and
 * reset grace. Assumes it is bound to the top module of the controller.
 */
module pmwc_power_ctrl_sva #(
    parameter RESTART_CYCLES = 1024
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire cpu_clk_en_o,
    input wire cpu_reset_o,
    input wire port_hold_o,
    input wire periph_run_o,
    input wire osc_en_o,
    input wire flash_pd_o,
    input wire ram_block_o,
    input wire wake_pulse_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int   rcnt;
    logic pd_seen;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Count oscillator-on cycles after a deep sleep until the CPU runs
    always @(posedge clk_i)
    begin
        if (!rst_n_i || cpu_clk_en_o)
        begin
            pd_seen <= 1'b0;
            rcnt    <= 0;
        end
        else
        begin
            if (flash_pd_o) pd_seen <= 1'b1;
            if (osc_en_o && pd_seen) rcnt <= rcnt + 1;
        end
    end
    AST_IDLE_CLK: assert property ($rose(port_hold_o) |-> !cpu_clk_en_o)
        else $error("idle entry left the cpu clock running");
    AST_IDLE_RUN: assert property (port_hold_o |->
        periph_run_o && osc_en_o && !flash_pd_o)
        else $error("peripherals stopped during idle");
    AST_PD_OFF: assert property (flash_pd_o |->
        !osc_en_o && !cpu_clk_en_o && !periph_run_o)
        else $error("deep sleep left clocks running");
    AST_PULSE: assert property (wake_pulse_o |=> !wake_pulse_o)
        else $error("wake pulse longer than one cycle");
    AST_WAKE_CLK: assert property (wake_pulse_o |-> ##[0:1] cpu_clk_en_o)
        else $error("cpu clock not resumed after wake");
    AST_RESTART: assert property ($rose(cpu_clk_en_o) && pd_seen |->
        rcnt >= RESTART_CYCLES && rcnt <= RESTART_CYCLES + 3)
        else $error("restart hold has the wrong length");
    AST_GRACE: assert property ($rose(ram_block_o) |->
        (cpu_clk_en_o && !cpu_reset_o)[*2] ##1 !ram_block_o)
        else $error("reset grace window wrong");
    AST_GRACE_IDLE: assert property ($rose(ram_block_o) |->
        $past(port_hold_o))
        else $error("ram block outside idle exit");
    CV_PD: cover property ($rose(cpu_clk_en_o) && pd_seen);
    CV_IDLE: cover property ($fell(port_hold_o) && wake_pulse_o);
    CV_GRACE: cover property ($fell(ram_block_o));
endmodule // pmwc_power_ctrl_sva

bind pmwc_power_ctrl pmwc_power_ctrl_sva #(
    .RESTART_CYCLES(RESTART_CYCLES)
) u_pmwc_power_ctrl_sva (.clk_i, .rst_n_i, .cpu_clk_en_o, .cpu_reset_o,
    .port_hold_o, .periph_run_o, .osc_en_o, .flash_pd_o, .ram_block_o,
    .wake_pulse_o);

// file: tb/pmwc_pin_model.sv
/*
 * Far-side model: external interrupt lines and the reset pin.
 * Assumes the bench asks for events with one-cycle request pulses.
 */
module pmwc_pin_model #(
    parameter int HOLD = 16
) (
    input  wire logic       clk_i,
    input  wire logic       wake_pulse_i,
    input  wire logic [5:0] irq_req_i,
    input  wire logic       rst_req_i,
    output logic      [5:0] ext_irq_line_n_o,
    output logic            rst_pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] held = 6'h00;
    int         rel  = 0;
    int         rcnt = 0;
    // Lines stay low until the CPU has run a while, then pull up
    always @(posedge clk_i)
    begin
        if (wake_pulse_i) rel <= 4;
        else if (rel > 0) rel <= rel - 1;
        if (rel == 1) held <= 6'h00;
        else held <= held | irq_req_i;
    end
    assign ext_irq_line_n_o = ~held;
    // Reset pin outlasts the restart timeout so the core resets cleanly
    always @(posedge clk_i)
    begin
        if (rst_req_i) rcnt <= HOLD;
        else if (rcnt > 0) rcnt <= rcnt - 1;
    end
    assign rst_pin_o = (rcnt > 0);
endmodule // pmwc_pin_model

// file: tb/power_mode_wakeup_control_tb.sv
/*
 * Bench for the power-mode controller: register access, Idle and
 * deep-sleep entry and every wake source. Assumes a 20 MHz clock.
 */
`include "pmwc_regs.vh"
module power_mode_wakeup_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RC = 8;
    logic        clk_i = 1'b0, rst_n_i = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid, rst_pin_i;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [5:0]  ext_irq_line_n_i;
    logic [7:0]  prt [0:4] = '{default: 8'hFF};
    logic        irq_pending_i = 0, wdt_wake_i = 0, rst_req = 0;
    logic [5:0]  irq_req = 6'h00;
    wire         cpu_clk_en_o, cpu_reset_o, port_hold_o, periph_run_o;
    wire         cmp_run_o, wdt_run_o, osc_en_o, flash_pd_o;
    wire         ram_block_o, wake_pulse_o;
    int          error_cnt = 0, compares = 0, cyc = 0, n;
    logic [31:0] rdat;
    logic [1:0]  rsp;

    pmwc_power_ctrl #(.RESTART_CYCLES(RC)) u_pmwc_power_ctrl (
        .clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .rst_pin_i, .ext_irq_line_n_i,
        .port1_pins_i(prt[4]), .port0_pins_i(prt[0]),
        .port2_pins_i(prt[1]), .port3_pins_i(prt[2]),
        .port5_pins_i(prt[3]), .irq_pending_i, .wdt_wake_i, .cpu_clk_en_o,
        .cpu_reset_o, .port_hold_o, .periph_run_o, .cmp_run_o, .wdt_run_o,
        .osc_en_o, .flash_pd_o, .ram_block_o, .wake_pulse_o);
    pmwc_pin_model #(.HOLD(RC + 8)) u_pmwc_pin_model (.clk_i,
        .wake_pulse_i(wake_pulse_o), .irq_req_i(irq_req),
        .rst_req_i(rst_req), .ext_irq_line_n_o(ext_irq_line_n_i),
        .rst_pin_o(rst_pin_i));

    always #25 clk_i = ~clk_i;
    // Cycle ceiling well above the several hundred cycles the tests take
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_of_test;
        end
    end
    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task chk_bit(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Write: address and data offered together, each dropped when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        aw = 0;
        w = 0;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(aw && w))
        begin
            @(negedge clk_i);
            if (s_axi_awvalid && s_axi_awready) aw = 1;
            if (s_axi_wvalid && s_axi_wready) w = 1;
            @(posedge clk_i);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
        end
        do @(negedge clk_i); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        @(posedge clk_i);
        s_axi_bready <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(negedge clk_i); while (!s_axi_arready);
        @(posedge clk_i);
        s_axi_arvalid <= 0;
        do @(negedge clk_i); while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge clk_i);
        s_axi_rready <= 0;
    endtask
    // Wait for the wake pulse, then check cause and cleared mode bits
    task wake(input logic [2:0] cause);
        n = 0;
        while (!wake_pulse_o && n < 300)
        begin
            @(negedge clk_i);
            n++;
        end
        chk_bit(wake_pulse_o, 1'b1);
        rd(`PMWC_ADDR_STATUS);
        chk_reg({29'h0, rdat[6:4]}, {29'h0, cause});
        rd(`PMWC_ADDR_PWR_CTRL);
        chk_reg(rdat, `PMWC_RST_WORD);
    endtask
    task sleep(input logic [31:0] mode);
        if (mode[1]) repeat (80) @(negedge clk_i);
        wr(`PMWC_ADDR_PWR_CTRL, mode);
        repeat (3) @(negedge clk_i);
    endtask

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1;
        for (int a = 0; a < 24; a += 4)
        begin
            rd(a[7:0]);
            chk_reg(rdat, `PMWC_RST_WORD);
        end
        wr(8'h40, 32'hFF);
        chk_reg({30'h0, rsp}, {30'h0, `PMWC_RESP_SLVERR});
        rd(8'h40);
        chk_reg({30'h0, rsp}, {30'h0, `PMWC_RESP_SLVERR});
        $display("test registers done");
        for (int s = 0; s < 4; s++)
        begin
            wr(`PMWC_ADDR_SEL_WAKE, 32'h1 << s);
            wr(`PMWC_ADDR_WAKE_CFG, {28'h0, s[1:0], s[1:0]});
            sleep(32'h1);
            chk_bit(cpu_clk_en_o, 1'b0);
            chk_bit(port_hold_o, 1'b1);
            chk_bit(periph_run_o, 1'b1);
            chk_bit(cmp_run_o, s[0]);
            chk_bit(wdt_run_o, s[1]);
            @(posedge clk_i) prt[4][s] <= 0;
            repeat (6) @(negedge clk_i);
            chk_bit(port_hold_o, 1'b1);
            @(posedge clk_i) prt[s][s] <= 0;
            wake(`PMWC_CAUSE_GPIO);
            @(posedge clk_i) prt <= '{default: 8'hFF};
        end
        $display("test idle gpio done");
        sleep(32'h1);
        @(posedge clk_i) irq_pending_i <= 1;
        wake(`PMWC_CAUSE_IRQ);
        chk_bit(n <= 3, 1'b1);
        irq_pending_i <= 0;
        sleep(32'h1);
        @(posedge clk_i) rst_req <= 1;
        @(posedge clk_i) rst_req <= 0;
        n = 0;
        while (!ram_block_o && n < 20) @(negedge clk_i) n++;
        chk_bit(ram_block_o, 1'b1);
        repeat (4) @(negedge clk_i);
        chk_bit(cpu_reset_o, 1'b1);
        repeat (20) @(negedge clk_i);
        chk_bit(cpu_reset_o, 1'b0);
        $display("test idle exits done");
        wr(`PMWC_ADDR_IRQ_CFG, 32'h0103);
        sleep(32'h2);
        chk_bit(flash_pd_o, 1'b1);
        chk_bit(osc_en_o, 1'b0);
        @(posedge clk_i) irq_req <= 6'h02;
        @(posedge clk_i) irq_req <= 6'h00;
        repeat (12) @(negedge clk_i);
        chk_bit(flash_pd_o, 1'b1);
        @(posedge clk_i) irq_req <= 6'h01;
        @(posedge clk_i) irq_req <= 6'h00;
        wake(`PMWC_CAUSE_IRQ);
        chk_bit(n >= RC, 1'b1);
        wr(`PMWC_ADDR_IRQ_CFG, 32'h0);
        repeat (8) @(negedge clk_i);
        sleep(32'h2);
        @(posedge clk_i) rst_req <= 1;
        @(posedge clk_i) rst_req <= 0;
        wake(`PMWC_CAUSE_RESET);
        repeat (20) @(negedge clk_i);
        wr(`PMWC_ADDR_P1_WAKE, 32'h80);
        wr(`PMWC_ADDR_WAKE_CFG, 32'h0);
        sleep(32'h2);
        @(posedge clk_i) wdt_wake_i <= 1;
        repeat (12) @(negedge clk_i);
        chk_bit(flash_pd_o, 1'b1);
        @(posedge clk_i) wdt_wake_i <= 0;
        @(posedge clk_i) prt[4][7] <= 0;
        wake(`PMWC_CAUSE_GPIO);
        @(posedge clk_i) prt[4][7] <= 1;
        wr(`PMWC_ADDR_WAKE_CFG, 32'h10);
        sleep(32'h2);
        @(posedge clk_i) wdt_wake_i <= 1;
        wake(`PMWC_CAUSE_WDT);
        wdt_wake_i <= 0;
        $display("test deep sleep done");
        end_of_test;
    end
endmodule // power_mode_wakeup_control_tb
